// ### shared/eeprom_data_access_unit_params.svh
// Offsets, field positions, reset values and timing counts of the NVM unit
`ifndef EEPROM_DATA_ACCESS_UNIT_PARAMS_SVH
`define EEPROM_DATA_ACCESS_UNIT_PARAMS_SVH

// ****************************************************************
// Store geometry
// ****************************************************************
`define NVM_DEPTH      32
`define NVM_AW         5
`define NVM_DW         8
`define SFR_W          8

// ****************************************************************
// Register offsets and bank values
// ****************************************************************
`define OFS_BANK_SEL   8'h04
`define OFS_NVM_LOC    8'h1a
`define OFS_NVM_BYTE   8'h1b
`define OFS_NVM_IRQ    8'h1c
`define OFS_NVM_CTRL   8'h40
`define BANK_ZERO      8'h00
`define BANK_ONE       8'h01

// ****************************************************************
// Field positions
// ****************************************************************
`define CTRL_RD_LAUNCH 0
`define CTRL_RD_PERMIT 1
`define CTRL_WR_LAUNCH 2
`define CTRL_WR_PERMIT 3
`define IRQ_NVM_EN     0
`define IRQ_NVM_FLAG   1
`define IRQ_MF_EN      2
`define IRQ_MF_FLAG    3

// ****************************************************************
// Reset values and timing
// ****************************************************************
`define RST_BYTE       8'h00
`define RST_LOC        5'h00
`define CLK_PERIOD_NS  25
`define WRITE_TIME_US  2000
`define WRITE_CYCLES   ((`WRITE_TIME_US * 1000) / `CLK_PERIOD_NS)
`define READ_TIME_NS   50
`define READ_CYCLES    ((`READ_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TIMER_W        17

`endif

// ### shared/eeprom_data_access_unit_pkg.sv
// Types of the NVM access unit
package eeprom_data_access_unit_pkg;
`include "eeprom_data_access_unit_params.svh"

  typedef enum logic [1:0] {
    IDLE,
    READING,
    WRITING
  } phase_e;

  typedef logic [`NVM_DEPTH-1:0][`NVM_DW-1:0] store_t;

endpackage

// ### logic/eeprom_data_access_unit.sv
// Register-driven access unit for the 32-byte nonvolatile data store
//
// Behaviour
// - Store holds 32 bytes, not directly mapped
// - Single-byte moves; location/byte bank0, control bank1
// - Location register five bits, upper bits zero
// - Control upper bits zero; control resets clear
// - Write permit gates every store write
// - Write launch starts write; hardware clears it
// - Write launch without permit does nothing
// - Read permit gates every store read
// - Read launch starts read; hardware clears it
// - Read launch without permit does nothing
// - After read launch clears, byte holds data
// - Fetched byte held until next operation
// - Internal timer times write; launch clear signals
// - Power-on clears permit and bank select
// - Write end sets both interrupt request flags
// - Interrupt needs three enables set
// - Service clears multi-function flag only

`timescale 1ns/10ps
`include "eeprom_data_access_unit_params.svh"

module eeprom_data_access_unit
  import eeprom_data_access_unit_pkg::*;
#(
  parameter int unsigned WRITE_CYCLES = `WRITE_CYCLES
) (
  // Clock and reset
  input  wire logic               mclk,
  input  wire logic               arst_n,
  // Special function register port
  input  wire logic [`SFR_W-1:0]  sfrAddr,
  input  wire logic               sfrWrite,
  input  wire logic               sfrRead,
  input  wire logic [`SFR_W-1:0]  sfrWdata,
  output logic      [`SFR_W-1:0]  sfrRdata,
  // Bank select held here for the address decoder of the core
  output logic      [`SFR_W-1:0]  bankSelect,
  // Interrupt handshake with the core
  input  wire logic               globalIrqEnable,
  input  wire logic               irqAck,
  output logic                    irqRequest,
  // Cycle in progress, for the power manager
  output logic                    nvmBusy
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    store_t                   mem;
    logic [`NVM_AW-1:0]       loc;
    logic [`NVM_DW-1:0]       byteReg;
    logic                     wrPermit;
    logic                     wrLaunch;
    logic                     rdPermit;
    logic                     rdLaunch;
    logic [`SFR_W-1:0]        bankSel;
    logic                     nvmIrqEn;
    logic                     nvmIrqFlag;
    logic                     mfIrqEn;
    logic                     mfIrqFlag;
    phase_e                   phase;
    logic [`TIMER_W-1:0]      timer;
    logic [`NVM_AW-1:0]       capLoc;
    logic [`NVM_DW-1:0]       capByte;
    logic [`SFR_W-1:0]        rdata;
    logic                     irqReq;
    logic                     busy;
  } state_s;

  state_s s_ff;
  state_s nxt_s;

  // WRITE_CYCLES must fit the timer; a larger value wraps in the cast
  localparam logic [`TIMER_W-1:0] WR_LAST =
    `TIMER_W'(WRITE_CYCLES - 1);
  localparam logic [`TIMER_W-1:0] RD_LAST =
    `TIMER_W'(`READ_CYCLES - 1);

  // ****************************************************************
  // Decode
  // ****************************************************************
  // Bank-qualified register match
  function automatic logic regHit(
    input logic [`SFR_W-1:0] addr,
    input logic [`SFR_W-1:0] bank,
    input logic [`SFR_W-1:0] ofs,
    input logic [`SFR_W-1:0] want
  );
    regHit = (addr == ofs) && (bank == want);
  endfunction

  // Cycle timer helpers, shared by the read and write phases
  function automatic logic [`TIMER_W-1:0] timerStep(
    input logic [`TIMER_W-1:0] t
  );
    timerStep = t + 1'b1;
  endfunction

  function automatic logic timerAt(
    input logic [`TIMER_W-1:0] t,
    input logic [`TIMER_W-1:0] last
  );
    timerAt = (t == last);
  endfunction

  logic hitBank;
  logic hitLoc;
  logic hitByte;
  logic hitIrq;
  logic hitCtrl;

  always_comb begin
    // Bank select answers whichever bank is selected
    hitBank = (sfrAddr == `OFS_BANK_SEL);
    hitLoc  = regHit(sfrAddr, s_ff.bankSel, `OFS_NVM_LOC,
                     `BANK_ZERO);
    hitByte = regHit(sfrAddr, s_ff.bankSel, `OFS_NVM_BYTE,
                     `BANK_ZERO);
    hitIrq  = regHit(sfrAddr, s_ff.bankSel, `OFS_NVM_IRQ,
                     `BANK_ZERO);
    // Only reachable once bank one is selected
    hitCtrl = regHit(sfrAddr, s_ff.bankSel, `OFS_NVM_CTRL,
                     `BANK_ONE);
  end

  // ****************************************************************
  // Read-back views
  // ****************************************************************
  logic [`SFR_W-1:0] locView;
  logic [`SFR_W-1:0] ctrlView;
  logic [`SFR_W-1:0] irqView;

  always_comb begin
    locView = {3'h0, s_ff.loc};
    ctrlView = 8'h00;
    ctrlView[`CTRL_WR_PERMIT] = s_ff.wrPermit;
    ctrlView[`CTRL_WR_LAUNCH] = s_ff.wrLaunch;
    ctrlView[`CTRL_RD_PERMIT] = s_ff.rdPermit;
    ctrlView[`CTRL_RD_LAUNCH] = s_ff.rdLaunch;
    irqView = 8'h00;
    irqView[`IRQ_NVM_EN]   = s_ff.nvmIrqEn;
    irqView[`IRQ_NVM_FLAG] = s_ff.nvmIrqFlag;
    irqView[`IRQ_MF_EN]    = s_ff.mfIrqEn;
    irqView[`IRQ_MF_FLAG]  = s_ff.mfIrqFlag;
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    nxt_s = s_ff;

    // Register reads answer one cycle later; unmapped reads give zero
    if (sfrRead) begin
      if (hitBank) begin
        nxt_s.rdata = s_ff.bankSel;
      end else if (hitLoc) begin
        nxt_s.rdata = locView;
      end else if (hitByte) begin
        nxt_s.rdata = s_ff.byteReg;
      end else if (hitIrq) begin
        nxt_s.rdata = irqView;
      end else if (hitCtrl) begin
        nxt_s.rdata = ctrlView;
      end else begin
        nxt_s.rdata = 8'h00;
      end
    end

    // Software writes come first so that hardware events win
    if (sfrWrite && hitBank) begin
      nxt_s.bankSel = sfrWdata;
    end
    if (sfrWrite && hitLoc) begin
      nxt_s.loc = sfrWdata[`NVM_AW-1:0];
    end
    if (sfrWrite && hitByte) begin
      nxt_s.byteReg = sfrWdata;
    end
    if (sfrWrite && hitIrq) begin
      nxt_s.nvmIrqEn   = sfrWdata[`IRQ_NVM_EN];
      nxt_s.nvmIrqFlag = sfrWdata[`IRQ_NVM_FLAG];
      nxt_s.mfIrqEn    = sfrWdata[`IRQ_MF_EN];
      nxt_s.mfIrqFlag  = sfrWdata[`IRQ_MF_FLAG];
    end
    if (irqAck) begin
      nxt_s.mfIrqFlag = 1'b0;
    end

    if (sfrWrite && hitCtrl) begin
      nxt_s.wrPermit = sfrWdata[`CTRL_WR_PERMIT];
      nxt_s.rdPermit = sfrWdata[`CTRL_RD_PERMIT];
      // Launch needs the permit already held; a busy unit
      // ignores further launches and clears of launch bits
      if (s_ff.phase == IDLE) begin
        // Both launch bits at once with the write permit held: the write wins, the read is dropped
        if (sfrWdata[`CTRL_WR_LAUNCH] && s_ff.wrPermit) begin
          nxt_s.wrLaunch = 1'b1;
          nxt_s.phase    = WRITING;
          nxt_s.timer    = '0;
          nxt_s.capLoc   = s_ff.loc;
          nxt_s.capByte  = s_ff.byteReg;
        end else if (sfrWdata[`CTRL_RD_LAUNCH] &&
                     s_ff.rdPermit) begin
          nxt_s.rdLaunch = 1'b1;
          nxt_s.phase    = READING;
          nxt_s.timer    = '0;
          nxt_s.capLoc   = s_ff.loc;
        end
      end
    end

    // Cycle sequencing
    case (s_ff.phase)
      IDLE: begin
        // Nothing to time; a launch above has already cleared the timer
      end
      READING: begin
        if (timerAt(s_ff.timer, RD_LAST)) begin
          nxt_s.byteReg  = s_ff.mem[s_ff.capLoc];
          nxt_s.rdLaunch = 1'b0;
          nxt_s.phase    = IDLE;
        end else begin
          nxt_s.timer = timerStep(s_ff.timer);
        end
      end
      WRITING: begin
        // Write time runs off its own counter, not software pacing
        if (timerAt(s_ff.timer, WR_LAST)) begin
          nxt_s.mem[s_ff.capLoc] = s_ff.capByte;
          nxt_s.wrLaunch   = 1'b0;
          nxt_s.phase      = IDLE;
          nxt_s.nvmIrqFlag = 1'b1;
          nxt_s.mfIrqFlag  = 1'b1;
        end else begin
          nxt_s.timer = timerStep(s_ff.timer);
        end
      end
      default: begin
        nxt_s.phase    = IDLE;
        nxt_s.wrLaunch = 1'b0;
        nxt_s.rdLaunch = 1'b0;
      end
    endcase

    // Registered request: set on the same edge as the flag, never a glitch
    nxt_s.irqReq = nxt_s.mfIrqFlag && nxt_s.mfIrqEn &&
                   nxt_s.nvmIrqEn && globalIrqEnable;
    nxt_s.busy = (nxt_s.phase != IDLE);
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  // Store contents clear at reset too: one struct, one reset value
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s_ff.mem        <= '0;
      s_ff.loc        <= `RST_LOC;
      s_ff.byteReg    <= `RST_BYTE;
      s_ff.wrPermit   <= 1'b0;
      s_ff.wrLaunch   <= 1'b0;
      s_ff.rdPermit   <= 1'b0;
      s_ff.rdLaunch   <= 1'b0;
      s_ff.bankSel    <= `BANK_ZERO;
      s_ff.nvmIrqEn   <= 1'b0;
      s_ff.nvmIrqFlag <= 1'b0;
      s_ff.mfIrqEn    <= 1'b0;
      s_ff.mfIrqFlag  <= 1'b0;
      s_ff.phase      <= IDLE;
      s_ff.timer      <= '0;
      s_ff.capLoc     <= `RST_LOC;
      s_ff.capByte    <= `RST_BYTE;
      s_ff.rdata      <= 8'h00;
      s_ff.irqReq     <= 1'b0;
      s_ff.busy       <= 1'b0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign sfrRdata   = s_ff.rdata;
  assign bankSelect = s_ff.bankSel;
  assign irqRequest = s_ff.irqReq;
  assign nvmBusy    = s_ff.busy;

endmodule // eeprom_data_access_unit

// ### verification/eeprom_data_access_unit_checker.sv
// Port-level assertions of the NVM access unit and their bind
`timescale 1ns/10ps
`include "eeprom_data_access_unit_params.svh"
module eeprom_data_access_unit_checker #(
  parameter int unsigned WRITE_CYCLES = 8
) (
  // Clock and reset
  input wire logic             mclk,
  input wire logic             arst_n,
  // Register port
  input wire logic [`SFR_W-1:0] sfrAddr,
  input wire logic             sfrWrite,
  input wire logic             sfrRead,
  input wire logic [`SFR_W-1:0] sfrWdata,
  input wire logic [`SFR_W-1:0] sfrRdata,
  input wire logic [`SFR_W-1:0] bankSelect,
  // Interrupt and status
  input wire logic             globalIrqEnable,
  input wire logic             irqAck,
  input wire logic             irqRequest,
  input wire logic             nvmBusy
);
  logic        wrGo;
  logic        wrOn_ff;
  logic [31:0] wrCnt_ff;
  logic ctlWr;
  logic rdPerm_ff;
  logic wrPerm_ff;

  // Permits shadowed here, since a launch is judged on the prior value
  assign ctlWr = sfrWrite && sfrAddr == `OFS_NVM_CTRL
                 && bankSelect == `BANK_ONE;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rdPerm_ff <= 1'b0;
      wrPerm_ff <= 1'b0;
    end else if (ctlWr) begin
      rdPerm_ff <= sfrWdata[`CTRL_RD_PERMIT];
      wrPerm_ff <= sfrWdata[`CTRL_WR_PERMIT];
    end
  end

  // Busy cycles of each write are counted, since the length is long
  assign wrGo = ctlWr && !nvmBusy && wrPerm_ff
                && sfrWdata[`CTRL_WR_LAUNCH];
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wrOn_ff  <= 1'b0;
      wrCnt_ff <= 32'h0;
    end else if (wrGo) begin
      wrOn_ff  <= 1'b1;
      wrCnt_ff <= 32'h0;
    end else if (wrOn_ff && nvmBusy) begin
      wrCnt_ff <= wrCnt_ff + 32'h1;
    end else begin
      wrOn_ff <= 1'b0;
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);

  bank_write_a:
    assert property (sfrWrite && sfrAddr == `OFS_BANK_SEL |=>
      bankSelect == $past(sfrWdata)) else $error("bank select not loaded");
  rd_start_a:
    assert property (ctlWr && !nvmBusy && rdPerm_ff && sfrWdata[0]
      && !sfrWdata[2] |=> nvmBusy [*2] ##1 !nvmBusy)
      else $error("read cycle length wrong");
  wr_start_a:
    assert property (wrGo |=> nvmBusy)
      else $error("write cycle did not start");
  wr_length_a:
    assert property (wrOn_ff && !nvmBusy |-> wrCnt_ff == WRITE_CYCLES)
      else $error("write cycle length wrong");
  wr_bound_a:
    assert property (wrOn_ff && nvmBusy |-> wrCnt_ff < WRITE_CYCLES)
      else $error("write cycle overran");
  no_start_a:
    assert property (ctlWr && !nvmBusy && !(wrPerm_ff && sfrWdata[2])
      && !(rdPerm_ff && sfrWdata[0]) |=> !nvmBusy)
      else $error("cycle began without permit");
  stay_idle_a:
    assert property (!nvmBusy && !ctlWr |=> !nvmBusy)
      else $error("cycle began without launch");
  irq_cause_a:
    assert property (irqRequest |-> $past(globalIrqEnable))
      else $error("request while globally masked");
  rdata_hold_a:
    assert property (!sfrRead |=> $stable(sfrRdata))
      else $error("read data moved without read");
  ctrl_upper_a:
    assert property (sfrRead && sfrAddr == `OFS_NVM_CTRL
      && bankSelect == `BANK_ONE |=> sfrRdata[7:4] == 4'h0)
      else $error("control upper bits not zero");
  loc_upper_a:
    assert property (sfrRead && sfrAddr == `OFS_NVM_LOC
      && bankSelect == `BANK_ZERO |=> sfrRdata[7:5] == 3'h0)
      else $error("location upper bits not zero");
  ctrl_hidden_a:
    assert property (sfrRead && sfrAddr == `OFS_NVM_CTRL
      && bankSelect == `BANK_ZERO |=> sfrRdata == 8'h00)
      else $error("control seen from bank zero");

  cover property (ctlWr && rdPerm_ff && sfrWdata[0] && !nvmBusy);
  cover property (ctlWr && wrPerm_ff && sfrWdata[2] && !nvmBusy);
  cover property ($rose(irqRequest));
endmodule // eeprom_data_access_unit_checker

bind eeprom_data_access_unit eeprom_data_access_unit_checker #(
  .WRITE_CYCLES(WRITE_CYCLES)
) i_checker (
  .mclk(mclk), .arst_n(arst_n), .sfrAddr(sfrAddr), .sfrWrite(sfrWrite),
  .sfrRead(sfrRead), .sfrWdata(sfrWdata), .sfrRdata(sfrRdata),
  .bankSelect(bankSelect), .globalIrqEnable(globalIrqEnable),
  .irqAck(irqAck), .irqRequest(irqRequest), .nvmBusy(nvmBusy)
);

// ### verification/eeprom_data_access_unit_tb.sv
// Self-checking bench of the NVM access unit
`timescale 1ns/10ps
`include "eeprom_data_access_unit_params.svh"
module eeprom_data_access_unit_tb;
  logic       mclk, arst_n, sfrWrite, sfrRead, globalIrqEnable, irqAck;
  logic [7:0] sfrAddr, sfrWdata, sfrRdata, bankSelect;
  logic       irqRequest, nvmBusy;
  int         miscompares, cmp_count;

  // Short write time keeps the run brief
  eeprom_data_access_unit #(.WRITE_CYCLES(8)) i_dut (
    .mclk(mclk), .arst_n(arst_n), .sfrAddr(sfrAddr), .sfrWrite(sfrWrite),
    .sfrRead(sfrRead), .sfrWdata(sfrWdata), .sfrRdata(sfrRdata),
    .bankSelect(bankSelect), .globalIrqEnable(globalIrqEnable),
    .irqAck(irqAck), .irqRequest(irqRequest), .nvmBusy(nvmBusy)
  );

  // ********************
  // Bus tasks
  // ********************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfrAddr <= a;
    sfrWdata <= d;
    sfrWrite <= 1'b1;
    @(posedge mclk);
    sfrWrite <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    sfrAddr <= a;
    sfrRead <= 1'b1;
    @(posedge mclk);
    sfrRead <= 1'b0;
    @(posedge mclk);
    chk(sfrRdata, exp);
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 40 && nvmBusy !== 1'b0; i++) @(posedge mclk);
    chk({7'h0, nvmBusy}, 8'h00);
  endtask

  // ********************
  // Scenarios
  // ********************
  task automatic t_reset();
    chk(bankSelect, `BANK_ZERO);
    rd(`OFS_NVM_LOC, 8'h00);
    rd(`OFS_NVM_CTRL, 8'h00);
    wr(`OFS_BANK_SEL, `BANK_ONE);
    chk(bankSelect, `BANK_ONE);
    rd(`OFS_NVM_CTRL, 8'h00);
  endtask
  task automatic t_refuse();
    // Launch bits go in separate writes
    wr(`OFS_NVM_CTRL, 8'h04);
    chk({7'h0, nvmBusy}, 8'h00);
    wr(`OFS_NVM_CTRL, 8'h01);
    chk({7'h0, nvmBusy}, 8'h00);
    rd(`OFS_NVM_CTRL, 8'h00);
    // Permit raised in the launching write itself is too late
    wr(`OFS_NVM_CTRL, 8'h0c);
    chk({7'h0, nvmBusy}, 8'h00);
    rd(`OFS_NVM_CTRL, 8'h08);
  endtask
  task automatic t_write();
    wr(`OFS_BANK_SEL, `BANK_ZERO);
    wr(`OFS_NVM_LOC, 8'hff);
    rd(`OFS_NVM_LOC, 8'h1f);
    wr(`OFS_NVM_BYTE, 8'ha5);
    wr(`OFS_NVM_IRQ, 8'h05);
    wr(`OFS_BANK_SEL, `BANK_ONE);
    globalIrqEnable <= 1'b0;
    wr(`OFS_NVM_CTRL, 8'h08);
    wr(`OFS_NVM_CTRL, 8'h0c);
    globalIrqEnable <= 1'b1;
    rd(`OFS_NVM_CTRL, 8'h0c);
    chk({7'h0, irqRequest}, 8'h00);
    // Location and byte change while the write is still running
    wr(`OFS_BANK_SEL, `BANK_ZERO);
    wr(`OFS_NVM_LOC, 8'h00);
    wr(`OFS_NVM_BYTE, 8'h3c);
    wait_idle();
    rd(`OFS_NVM_IRQ, 8'h0f);
    chk({7'h0, irqRequest}, 8'h01);
    irqAck <= 1'b1;
    @(posedge mclk);
    irqAck <= 1'b0;
    @(posedge mclk);
    rd(`OFS_NVM_IRQ, 8'h07);
    chk({7'h0, irqRequest}, 8'h00);
    wr(`OFS_NVM_IRQ, 8'h05);
    rd(`OFS_NVM_IRQ, 8'h05);
  endtask
  task automatic t_read();
    wr(`OFS_NVM_LOC, 8'h1f);
    wr(`OFS_BANK_SEL, `BANK_ONE);
    wr(`OFS_NVM_CTRL, 8'h02);
    wr(`OFS_NVM_CTRL, 8'h03);
    wait_idle();
    rd(`OFS_NVM_CTRL, 8'h02);
    wr(`OFS_BANK_SEL, `BANK_ZERO);
    rd(`OFS_NVM_BYTE, 8'ha5);
    wr(`OFS_NVM_LOC, 8'h00);
    rd(`OFS_NVM_BYTE, 8'ha5);
    // Location zero must not have taken the late byte
    wr(`OFS_BANK_SEL, `BANK_ONE);
    wr(`OFS_NVM_CTRL, 8'h03);
    wait_idle();
    wr(`OFS_BANK_SEL, `BANK_ZERO);
    rd(`OFS_NVM_BYTE, 8'h00);
  endtask

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  initial begin
    {arst_n, sfrWrite, sfrRead, irqAck} = 4'h0;
    sfrAddr = 8'h00;
    sfrWdata = 8'h00;
    globalIrqEnable = 1'b1;
    miscompares = 0;
    cmp_count = 0;
    repeat (2) @(posedge mclk);
    arst_n <= 1'b1;
    @(posedge mclk);
    t_reset();
    t_refuse();
    t_write();
    t_read();
    finish_test();
  end
  // Scenarios need about 85 cycles
  initial begin
    repeat (2000) @(posedge mclk);
    miscompares++;
    finish_test();
  end
endmodule // eeprom_data_access_unit_tb
